/* logic/vpm_pkg.sv */
package vpm_pkg;
   // ************************************************************
   // register map (byte addresses, one aligned word each)
   // ************************************************************
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] VO_SEL_OFS = 12'h004;
   localparam logic [ADDR_W-1:0] MEM_SEL_OFS = 12'h008;
   localparam logic [31:0] VO_WMASK = 32'h007fffff;
   localparam logic [31:0] MEM_WMASK = 32'h00000fff;
   localparam logic [31:0] VO_RST = 32'h00000000;
   localparam logic [31:0] MEM_RST = 32'h00000000;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int VO_PCLK_BIT = 22;
   localparam int VO_EXTERNAL_VIDEO_CLOCK_MSB = 21;
   localparam int VO_FIELD_MSB = 19;
   localparam int VO_DISPLAY_CONTROL_SELECT_BIT = 17;
   localparam int VO_SYNC_BIT = 16;
   localparam int VO_COUT0_MSB = 15;
   localparam int MEM_BOOT_LSB = 1;
   localparam int MEM_BOOT_W = 4;
   localparam int MEM_GIO_LSB = 5;
   localparam int MEM_GIO_W = 7;

   // ************************************************************
   // pins: index i carries general io line 68+i when in io mode
   // ************************************************************
   localparam int NUM_PINS = 14;
   localparam int PIN_PCLK = 0;
   localparam int PIN_EXTERNAL_VIDEO_CLOCK = 1;
   localparam int PIN_FIELD = 2;
   localparam int PIN_DISPLAY_CONTROL_SELECT = 3;
   localparam int PIN_HSYNC = 4;
   localparam int PIN_VSYNC = 5;
   localparam int PIN_COUT0 = 6;
   localparam int NUM_COUT = 8;

   // uniform per-pin mode code
   localparam logic [1:0] MODE_GIO = 2'h0;
   localparam logic [1:0] MODE_VID = 2'h1;
   localparam logic [1:0] MODE_ALT2 = 2'h2;
   localparam logic [1:0] MODE_ALT3 = 2'h3;

   // pins whose alternate codes exist; others are reserved
   localparam logic [NUM_PINS-1:0] ALT2_OK = 14'h3fc6;
   localparam logic [NUM_PINS-1:0] ALT3_OK = 14'h0f06;
   // video function that is an input on its pin
   localparam logic [NUM_PINS-1:0] VID_INPUT = 14'h0002;
endpackage

/* logic/vpm_pin_mux.sv */
`timescale 1ns/1ps
// Function
// - pixel clock pin: 0 clock, 1 io 68
// - ext clock pin: io69, clock in, blue2, pulse_width_channel_3
// - field pin: io70, field, red2, pulse_width_channel_3
// - display pin: 0 enable/brightness, 1 io71
// - sync pins: 0 syncs, 1 io72/73
// - colour bit0: io74, colour, pulse_width_channel_3, reserved
// - colour bit1: io75, colour, pulse_width_channel_3, reserved
// - colour bit2: io76, colour, pwm2, real_time_output_3
// - colour bit3: io77, colour, pwm2, rto2
// - colour bit4: io78, colour, pwm2, rto1
// - colour bit5: io79, colour, pwm2, rto0
// - colour bit6: io80, colour, pwm1, reserved
// - colour bit7: io81, colour, pwm0, reserved
// - memory select resets to zero; bits 4..1 load from boot pins on the first edge after release
// - memory select: twelve bits, upper zero
// - memory single-bit selects: 1 means io
// - memory bits 4..1 load from boot pins
module vpm_pin_mux
   import vpm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] boot_memory_config_pins,
   output logic [11:0] memory_if_pin_select,
   output logic [MEM_GIO_W-1:0] memory_if_gio_mode,
   input wire logic [NUM_PINS-1:0] gio_out,
   input wire logic [NUM_PINS-1:0] gio_oe,
   output logic [NUM_PINS-1:0] gio_in,
   input wire logic [NUM_PINS-1:0] vid_out,
   input wire logic [NUM_PINS-1:0] vid_oe,
   input wire logic blue_bit_2,
   input wire logic red_bit_2,
   input wire logic [3:0] pwm_out,
   input wire logic [3:0] rto_out,
   output logic external_video_clock,
   input wire logic [NUM_PINS-1:0] pad_in,
   output logic [NUM_PINS-1:0] pad_out,
   output logic [NUM_PINS-1:0] pad_oe
);

   // ************************************************************
   // apb slave
   // ************************************************************
   logic [31:0] vo_sel_r;
   logic [31:0] mem_sel_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic boot_loaded_r;
   logic [31:0] bmask;
   logic wr_go;
   logic hit_vo;
   logic hit_mem;

   assign bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   assign hit_vo = (paddr == VO_SEL_OFS);
   assign hit_mem = (paddr == MEM_SEL_OFS);
   assign wr_go = psel && penable && pready_r && pwrite;

   // answer prepared in setup, so access completes with no wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         pready_r <= psel && !penable;
         pslverr_r <= psel && !penable && !hit_vo && !hit_mem;
         if (psel && !penable && !pwrite) begin
            // reserved bits are never stored, so they read zero
            prdata_r <= hit_vo ? vo_sel_r : (hit_mem ? mem_sel_r : 32'h00000000);
         end
      end
   end

   // video-out select register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vo_sel_r <= VO_RST;
      end else if (wr_go && hit_vo) begin
         vo_sel_r <= (vo_sel_r & ~(bmask & VO_WMASK)) | (pwdata & bmask & VO_WMASK);
      end
   end

   // memory select; boot straps caught on first edge after release,
   // since an async reset may only load constants
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_sel_r <= MEM_RST;
         boot_loaded_r <= 1'b0;
      end else if (!boot_loaded_r) begin
         boot_loaded_r <= 1'b1;
         mem_sel_r[MEM_BOOT_LSB +: MEM_BOOT_W] <= boot_memory_config_pins;
      end else if (wr_go && hit_mem) begin
         mem_sel_r <= (mem_sel_r & ~(bmask & MEM_WMASK)) | (pwdata & bmask & MEM_WMASK);
      end
   end

   // memory-interface selects go out as plain levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         memory_if_pin_select <= 12'h000;
         memory_if_gio_mode <= 7'h00;
      end else begin
         memory_if_pin_select <= mem_sel_r[11:0];
         memory_if_gio_mode <= mem_sel_r[MEM_GIO_LSB +: MEM_GIO_W];
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   // ************************************************************
   // per-pin mode decode
   // ************************************************************
   logic [1:0] pin_mode [NUM_PINS];
   logic [NUM_PINS-1:0] alt2_val;
   logic [NUM_PINS-1:0] alt3_val;

   // single-bit selects: 0 is the video function, 1 is io
   assign pin_mode[PIN_PCLK] = vo_sel_r[VO_PCLK_BIT] ? MODE_GIO : MODE_VID;
   assign pin_mode[PIN_EXTERNAL_VIDEO_CLOCK] = vo_sel_r[VO_EXTERNAL_VIDEO_CLOCK_MSB -: 2];
   assign pin_mode[PIN_FIELD] = vo_sel_r[VO_FIELD_MSB -: 2];
   assign pin_mode[PIN_DISPLAY_CONTROL_SELECT] = vo_sel_r[VO_DISPLAY_CONTROL_SELECT_BIT] ? MODE_GIO : MODE_VID;
   assign pin_mode[PIN_HSYNC] = vo_sel_r[VO_SYNC_BIT] ? MODE_GIO : MODE_VID;
   assign pin_mode[PIN_VSYNC] = vo_sel_r[VO_SYNC_BIT] ? MODE_GIO : MODE_VID;

   // colour-out fields already use the uniform code
   for (genvar k = 0; k < NUM_COUT; k++) begin : g_cout
      assign pin_mode[PIN_COUT0+k] = vo_sel_r[VO_COUT0_MSB-2*k -: 2];
   end

   // alternate sources per pin, pin 13 leftmost
   assign alt2_val = {pwm_out[0], pwm_out[1], {4{pwm_out[2]}}, {2{pwm_out[3]}},
                      3'h0, red_bit_2, blue_bit_2, 1'b0};
   assign alt3_val = {2'h0, rto_out[0], rto_out[1], rto_out[2], rto_out[3],
                      5'h00, pwm_out[3], pwm_out[3], 1'b0};

   // ************************************************************
   // pad drive and function inputs
   // ************************************************************
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      // reserved codes leave the pin undriven rather than guessing
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pad_out[i] <= 1'b0;
            pad_oe[i] <= 1'b0;
         end else begin
            unique case (pin_mode[i])
               MODE_GIO: begin
                  pad_out[i] <= gio_out[i];
                  pad_oe[i] <= gio_oe[i];
               end
               MODE_VID: begin
                  pad_out[i] <= vid_out[i] & ~VID_INPUT[i];
                  pad_oe[i] <= vid_oe[i] & ~VID_INPUT[i];
               end
               MODE_ALT2: begin
                  pad_out[i] <= alt2_val[i] & ALT2_OK[i];
                  pad_oe[i] <= ALT2_OK[i];
               end
               MODE_ALT3: begin
                  pad_out[i] <= alt3_val[i] & ALT3_OK[i];
                  pad_oe[i] <= ALT3_OK[i];
               end
            endcase
         end
      end

      // deselected io line sees a steady low
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            gio_in[i] <= 1'b0;
         end else begin
            gio_in[i] <= (pin_mode[i] == MODE_GIO) ? pad_in[i] : 1'b0;
         end
      end
   end

   // external clock only reaches the video back end when selected
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         external_video_clock <= 1'b0;
      end else begin
         external_video_clock <= (pin_mode[PIN_EXTERNAL_VIDEO_CLOCK] == MODE_VID) ?
            pad_in[PIN_EXTERNAL_VIDEO_CLOCK] : 1'b0;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_vo_rsvd;
      psel && !penable && !pwrite && hit_vo |=> prdata[31:23] == 9'h000;
   endproperty
   a_vo_rsvd: assert property (p_vo_rsvd) else $error("reserved bits read nonzero");

   property p_pclk_gio;
      vo_sel_r[VO_PCLK_BIT] |=> pad_out[PIN_PCLK] == $past(gio_out[PIN_PCLK])
         && pad_oe[PIN_PCLK] == $past(gio_oe[PIN_PCLK]);
   endproperty
   a_pclk_gio: assert property (p_pclk_gio) else $error("pixel clock pin not io");

   property p_ext_blue;
      pin_mode[PIN_EXTERNAL_VIDEO_CLOCK] == MODE_ALT2 |=> pad_oe[PIN_EXTERNAL_VIDEO_CLOCK]
         && pad_out[PIN_EXTERNAL_VIDEO_CLOCK] == $past(blue_bit_2);
   endproperty
   a_ext_blue: assert property (p_ext_blue) else $error("ext clock pin not blue2");

   property p_field_pwm;
      pin_mode[PIN_FIELD] == MODE_ALT3 |=> pad_oe[PIN_FIELD]
         && pad_out[PIN_FIELD] == $past(pwm_out[3]);
   endproperty
   a_field_pwm: assert property (p_field_pwm) else $error("field pin not pulse_width_channel_3");

   property p_sync_vid;
      !vo_sel_r[VO_SYNC_BIT] |=> pad_out[PIN_VSYNC] == $past(vid_out[PIN_VSYNC])
         && pad_out[PIN_HSYNC] == $past(vid_out[PIN_HSYNC]);
   endproperty
   a_sync_vid: assert property (p_sync_vid) else $error("sync pins not video");

   property p_display_control_select_gio;
      vo_sel_r[VO_DISPLAY_CONTROL_SELECT_BIT] |=> pad_out[PIN_DISPLAY_CONTROL_SELECT] == $past(gio_out[PIN_DISPLAY_CONTROL_SELECT])
         && pad_oe[PIN_DISPLAY_CONTROL_SELECT] == $past(gio_oe[PIN_DISPLAY_CONTROL_SELECT]);
   endproperty
   a_display_control_select_gio: assert property (p_display_control_select_gio) else $error("display pin not io");

   property p_ext_in;
      pin_mode[PIN_EXTERNAL_VIDEO_CLOCK] == MODE_VID |=> !pad_oe[PIN_EXTERNAL_VIDEO_CLOCK]
         && external_video_clock == $past(pad_in[PIN_EXTERNAL_VIDEO_CLOCK]);
   endproperty
   a_ext_in: assert property (p_ext_in) else $error("ext clock input not passed");

   property p_mem_rsvd;
      psel && !penable && !pwrite && hit_mem |=> prdata[31:12] == 20'h00000;
   endproperty
   a_mem_rsvd: assert property (p_mem_rsvd) else $error("memory reserved bits nonzero");

   property p_cout0_rsvd;
      pin_mode[PIN_COUT0] == MODE_ALT3 |=> !pad_oe[PIN_COUT0];
   endproperty
   a_cout0_rsvd: assert property (p_cout0_rsvd) else $error("reserved code drives pin");

   property p_cout0_pwm;
      pin_mode[PIN_COUT0] == MODE_ALT2 |=> pad_oe[PIN_COUT0]
         && pad_out[PIN_COUT0] == $past(pwm_out[3]);
   endproperty
   a_cout0_pwm: assert property (p_cout0_pwm) else $error("colour bit0 not pulse_width_channel_3");

   property p_cout1_pwm;
      pin_mode[PIN_COUT0+1] == MODE_ALT2 |=> pad_oe[PIN_COUT0+1]
         && pad_out[PIN_COUT0+1] == $past(pwm_out[3]);
   endproperty
   a_cout1_pwm: assert property (p_cout1_pwm) else $error("colour bit1 not pulse_width_channel_3");

   property p_cout2_rto;
      pin_mode[PIN_COUT0+2] == MODE_ALT3 |=> pad_out[PIN_COUT0+2] == $past(rto_out[3]);
   endproperty
   a_cout2_rto: assert property (p_cout2_rto) else $error("colour bit2 not real_time_output_3");

   property p_cout3_rto;
      pin_mode[PIN_COUT0+3] == MODE_ALT3 |=> pad_out[PIN_COUT0+3] == $past(rto_out[2]);
   endproperty
   a_cout3_rto: assert property (p_cout3_rto) else $error("colour bit3 not rto2");

   property p_cout4_rto;
      pin_mode[PIN_COUT0+4] == MODE_ALT3 |=> pad_out[PIN_COUT0+4] == $past(rto_out[1]);
   endproperty
   a_cout4_rto: assert property (p_cout4_rto) else $error("colour bit4 not rto1");

   property p_cout5_rto;
      pin_mode[PIN_COUT0+5] == MODE_ALT3 |=> pad_out[PIN_COUT0+5] == $past(rto_out[0]);
   endproperty
   a_cout5_rto: assert property (p_cout5_rto) else $error("colour bit5 not rto0");

   property p_cout6_pwm;
      pin_mode[PIN_COUT0+6] == MODE_ALT2 |=> pad_oe[PIN_COUT0+6]
         && pad_out[PIN_COUT0+6] == $past(pwm_out[1]);
   endproperty
   a_cout6_pwm: assert property (p_cout6_pwm) else $error("colour bit6 not pwm1");

   property p_cout7_pwm;
      pin_mode[PIN_COUT0+7] == MODE_ALT2 |=> pad_out[PIN_COUT0+7] == $past(pwm_out[0]);
   endproperty
   a_cout7_pwm: assert property (p_cout7_pwm) else $error("colour bit7 not pwm0");

   property p_gio_idle;
      pin_mode[PIN_DISPLAY_CONTROL_SELECT] != MODE_GIO ##1 pin_mode[PIN_DISPLAY_CONTROL_SELECT] != MODE_GIO |-> !gio_in[PIN_DISPLAY_CONTROL_SELECT];
   endproperty
   a_gio_idle: assert property (p_gio_idle) else $error("deselected io input moves");

   property p_boot_load;
      $rose(boot_loaded_r) |->
         mem_sel_r[MEM_BOOT_LSB +: MEM_BOOT_W] == $past(boot_memory_config_pins);
   endproperty
   a_boot_load: assert property (p_boot_load) else $error("boot straps not loaded");

   property p_mem_gio;
      ##1 1'b1 |-> memory_if_gio_mode == $past(mem_sel_r[MEM_GIO_LSB +: MEM_GIO_W]);
   endproperty
   a_mem_gio: assert property (p_mem_gio) else $error("memory io modes lag wrong");
endmodule

/* testbench/vpm_pin_mux_bench.sv */
`timescale 1ns/1ps
module vpm_pin_mux_bench;
   import vpm_pkg::*;
   // ************************************************************
   // stimulus and observed signals
   // ************************************************************
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hf;
   logic [3:0] boot = 4'h2;
   logic [3:0] pwm_out = '0;
   logic [3:0] rto_out = '0;
   logic blue_bit_2 = 1'b0;
   logic red_bit_2 = 1'b0;
   logic [NUM_PINS-1:0] gio_out = '0, gio_oe = '0, vid_out = '0, vid_oe = '0, pad_in = '0;
   logic [NUM_PINS-1:0] gio_in, pad_out, pad_oe;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, external_video_clock;
   logic [11:0] memory_if_pin_select;
   logic [MEM_GIO_W-1:0] memory_if_gio_mode;
   logic [31:0] v;
   int n_fail = 0;
   int check_count = 0;

   always #5 pclk = ~pclk;

   vpm_pin_mux dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .boot_memory_config_pins(boot),
      .memory_if_pin_select(memory_if_pin_select), .memory_if_gio_mode(memory_if_gio_mode),
      .gio_out(gio_out), .gio_oe(gio_oe), .gio_in(gio_in), .vid_out(vid_out),
      .vid_oe(vid_oe), .blue_bit_2(blue_bit_2), .red_bit_2(red_bit_2), .pwm_out(pwm_out),
      .rto_out(rto_out), .external_video_clock(external_video_clock), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe));

   // ************************************************************
   // helpers
   // ************************************************************
   task close_out;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer, entered just after a rising edge; idle edge after it
   task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle count assumed; only the watchdog ends a stuck wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic exp_err);
      apb(1'b0, a, 32'h0);
      chk("read data", exp, rd);
      chk("slave error", {31'h0, exp_err}, {31'h0, err});
   endtask

   // flip inverts every source so a stuck path cannot match twice
   task set_src(input logic f);
      gio_out <= 14'h2a5c ^ {NUM_PINS{f}};
      gio_oe <= 14'h1b3d ^ {NUM_PINS{f}};
      vid_out <= 14'h0ff0 ^ {NUM_PINS{f}};
      vid_oe <= 14'h2d6b ^ {NUM_PINS{f}};
      pad_in <= 14'h1e33 ^ {NUM_PINS{f}};
      pwm_out <= 4'h5 ^ {4{f}};
      rto_out <= 4'h9 ^ {4{f}};
      blue_bit_2 <= ~f;
      red_bit_2 <= f;
   endtask

   function automatic logic [1:0] mode_of(input logic [31:0] s, input int i);
      if (i == 0)
         return s[22] ? MODE_GIO : MODE_VID;
      if (i == 3)
         return s[17] ? MODE_GIO : MODE_VID;
      if (i == 4 || i == 5)
         return s[16] ? MODE_GIO : MODE_VID;
      if (i == 1)
         return s[21:20];
      if (i == 2)
         return s[19:18];
      return s[27-2*i -: 2];
   endfunction

   // expected pad state worked out per pin from the select word
   task pins(input logic [31:0] s);
      logic [NUM_PINS-1:0] eo, ee, eg, a2, a3;
      logic [1:0] m;
      a2 = {pwm_out[0], pwm_out[1], {4{pwm_out[2]}}, {2{pwm_out[3]}}, 3'b000, red_bit_2,
         blue_bit_2, 1'b0};
      a3 = {2'b00, rto_out[0], rto_out[1], rto_out[2], rto_out[3], 5'b00000,
         {2{pwm_out[3]}}, 1'b0};
      for (int i = 0; i < NUM_PINS; i++) begin
         m = mode_of(s, i);
         eg[i] = (m == MODE_GIO) & pad_in[i];
         case (m)
            MODE_GIO: begin
               eo[i] = gio_out[i];
               ee[i] = gio_oe[i];
            end
            MODE_VID: begin
               eo[i] = vid_out[i];
               ee[i] = vid_oe[i] & (i != 1);
            end
            MODE_ALT2: begin
               eo[i] = a2[i];
               ee[i] = 1'b1;
            end
            default: begin
               // code 3 is reserved on colour bits 0, 1, 6 and 7
               eo[i] = a3[i];
               ee[i] = !(i inside {6, 7, 12, 13});
            end
         endcase
      end
      chk("pad_oe", 32'(ee), 32'(pad_oe));
      chk("pad_out", 32'(eo & ee), 32'(pad_out & ee));
      chk("gio_in", 32'(eg), 32'(gio_in));
      chk("ext clock", 32'(mode_of(s, 1) == MODE_VID && pad_in[1]),
         32'(external_video_clock));
   endtask

   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rchk(VO_SEL_OFS, 32'h0, 1'b0);
      rchk(MEM_SEL_OFS, 32'h4, 1'b0);
      // software keeps the reserved upper bits at zero
      apb(1'b1, VO_SEL_OFS, 32'h007fffff);
      rchk(VO_SEL_OFS, 32'h007fffff, 1'b0);
      // only the lowest byte lane is written
      pstrb <= 4'h1;
      apb(1'b1, VO_SEL_OFS, 32'h00000000);
      pstrb <= 4'hf;
      rchk(VO_SEL_OFS, 32'h007fff00, 1'b0);
      for (int k = 0; k < 2; k++) begin
         v = k ? 32'h0000055a : 32'hffffffff;
         apb(1'b1, MEM_SEL_OFS, v);
         rchk(MEM_SEL_OFS, v & 32'h00000fff, 1'b0);
         repeat (2) @(posedge pclk);
         chk("mem select out", {20'h0, v[11:0]}, {20'h0, memory_if_pin_select});
         chk("mem io mode", {25'h0, v[11:5]}, {25'h0, memory_if_gio_mode});
      end
      // unmapped places answer with an error and read zero
      apb(1'b1, 12'h00c, 32'hffffffff);
      rchk(12'h00c, 32'h0, 1'b1);
      rchk(12'h000, 32'h0, 1'b1);
      // every code of every select, sources in both polarities
      for (int f = 0; f < 2; f++) begin
         set_src(f[0]);
         for (int c = 0; c < 4; c++) begin
            v = {9'h0, c[0], c[1:0], c[1:0], c[0], c[0], {8{c[1:0]}}};
            apb(1'b1, VO_SEL_OFS, v);
            repeat (3) @(posedge pclk);
            pins(v);
         end
      end
      // second reset in mid-run with another strap pattern
      boot <= 4'hd;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rchk(MEM_SEL_OFS, 32'h1a, 1'b0);
      rchk(VO_SEL_OFS, 32'h0, 1'b0);
      pins(32'h0);
      close_out;
   end

   // whole run needs well under a thousand cycles; this only cuts a hang
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      close_out;
   end
endmodule
